// ---- src/ppi_pkg.sv ----
// Purpose: shared constants for the periodic interrupt unit
// Assumes: 8-bit register port, 10 MHz system clock
// Notes: register offsets are word indices on the plain port
package ppi_pkg;

  localparam logic [1:0] PPI_ADDR_CLK_CTRL = 2'h0;
  localparam logic [1:0] PPI_ADDR_KB_EN = 2'h1;
  localparam logic [1:0] PPI_ADDR_KB_STAT = 2'h2;

  // drive_and_periodic_clock_ctrl fields
  localparam int PPI_CLKS_LSB = 0;
  localparam int PPI_DRV_LSB = 2;
  localparam int PPI_PEND_BIT = 7;
  // keyboard_and_period_enable fields
  localparam int PPI_KBIE_LSB = 0;
  localparam int PPI_PSEL_LSB = 4;
  // keyboard_status_control fields
  localparam int PPI_KEYBOARD_SENSITIVITY_BIT = 0;
  localparam int PPI_IMASK_BIT = 1;
  localparam int PPI_KEYBOARD_ACKNOWLEDGE_BIT = 2;
  localparam int PPI_KEYBOARD_FLAG_BIT = 3;

  localparam logic [7:0] PPI_RESET_BYTE = 8'h00;

  localparam logic [1:0] PPI_CLK_RC = 2'h0;
  localparam logic [1:0] PPI_CLK_EXT = 2'h1;
  localparam logic [1:0] PPI_CLK_XTAL = 2'h2;

  localparam int PPI_CNT_W = 15;
  localparam logic [2:0] PPI_PSEL_OFF = 3'h0;
  localparam int PPI_BASE_LOG2 = 8;

endpackage

// ---- src/ppi_tick_if.sv ----
// Purpose: carries the selected count tick between clock pick and counter
// Assumes: single clock domain
// Notes: none
`timescale 1ns/100ps
interface ppi_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

// ---- src/ppi_clk_pick.sv ----
// Purpose: edge-detect the chosen count source and emit a one-cycle tick
// Assumes: source levels synchronous to clk
// Notes: sources must run well below clk
`timescale 1ns/100ps
module ppi_clk_pick
  import ppi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] clk_sel,
  input wire logic rc_clock,
  input wire logic ext_clock,
  input wire logic xtal_clock,
  ppi_tick_if.src tk
);

  typedef struct packed {
    logic prev;
  } ppi_pick_t;

  ppi_pick_t st;
  ppi_pick_t next_st;
  logic level;

  always_comb begin
    if (clk_sel == PPI_CLK_RC) begin
      level = rc_clock;
    end else if (clk_sel == PPI_CLK_EXT) begin
      level = ext_clock;
    end else if (clk_sel == PPI_CLK_XTAL) begin
      level = xtal_clock;
    end else begin
      level = 1'b0;
    end
    next_st.prev = level;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Rising edge of the picked source counts once
  assign tk.tick = level & ~st.prev;

endmodule

// ---- src/ppi_unit.sv ----
// Purpose: periodic interrupt unit with its shared keyboard controls
// Assumes: sources arrive as levels synchronous to clk
// Notes: keyboard pin internals live elsewhere; only shared bits kept here
//
// Contract
// - clock select 00 RC, 01 external pin, 10 crystal, 11 reserved
// - period select 000 off, else 512 to 32768 counts
// - reaching period raises request and sets pending latch
// - pending latch readable as status, 1 pending
// - request goes to keyboard unit, not directly to CPU
// - acknowledge write 1 clears latch and keyboard request, reads 0
// - counting continues in wait and stop when source supplied
// - keyboard sensitivity read/write, reset 0, 1 edge and level
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
module ppi_unit
  import ppi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic rc_clock,
  input wire logic ext_clock,
  input wire logic xtal_clock,
  input wire logic keyboard_flag,
  output logic periodic_request,
  output logic keyboard_acknowledge,
  output logic keyboard_sensitivity,
  output logic keyboard_int_mask,
  output logic [3:0] keyboard_pin_enable,
  output logic [3:0] port_drive_enable_bits
);

  typedef struct packed {
    logic [1:0] clk_sel;
    logic [3:0] drive;
    logic pending;
    logic [3:0] kb_en;
    logic [2:0] psel;
    logic sens;
    logic imask;
    logic ack;
    logic req;
    logic [PPI_CNT_W-1:0] count;
    logic [7:0] rdata;
  } ppi_state_t;

  ppi_state_t st;
  ppi_state_t next_st;
  ppi_tick_if tk_if ();

  ////////////////////////////////////////////////////////////////////////
  ppi_clk_pick u_pick (
    .clk(clk),
    .rst_n(rst_n),
    .clk_sel(st.clk_sel),
    .rc_clock(rc_clock),
    .ext_clock(ext_clock),
    .xtal_clock(xtal_clock),
    .tk(tk_if.src)
  );

  ////////////////////////////////////////////////////////////////////////
  logic [PPI_CNT_W:0] period;
  logic hit;
  logic ack_wr;

  always_comb begin
    period = (PPI_CNT_W+1)'(1) << (PPI_BASE_LOG2 + int'(st.psel));
    hit = (st.psel != PPI_PSEL_OFF) && tk_if.tick &&
          ({1'b0, st.count} == period - (PPI_CNT_W+1)'(1));
    ack_wr = wr && (addr == PPI_ADDR_KB_STAT) && wdata[PPI_KEYBOARD_ACKNOWLEDGE_BIT];

    next_st = st;
    next_st.ack = ack_wr;
    next_st.rdata = 8'h00;

    if (wr) begin
      if (addr == PPI_ADDR_CLK_CTRL) begin
        next_st.clk_sel = wdata[PPI_CLKS_LSB +: 2];
        next_st.drive = wdata[PPI_DRV_LSB +: 4];
      end else if (addr == PPI_ADDR_KB_EN) begin
        next_st.kb_en = wdata[PPI_KBIE_LSB +: 4];
        next_st.psel = wdata[PPI_PSEL_LSB +: 3];
      end else if (addr == PPI_ADDR_KB_STAT) begin
        next_st.sens = wdata[PPI_KEYBOARD_SENSITIVITY_BIT];
        next_st.imask = wdata[PPI_IMASK_BIT];
      end
    end

    if (st.psel == PPI_PSEL_OFF) begin
      next_st.count = '0;
    end else if (hit) begin
      next_st.count = '0;
    end else if (tk_if.tick) begin
      next_st.count = st.count + PPI_CNT_W'(1);
    end

    if (ack_wr) begin
      next_st.pending = 1'b0;
      next_st.req = 1'b0;
    end
    // latch on period; set beats clear
    if (hit) begin
      next_st.pending = 1'b1;
      next_st.req = 1'b1;
    end
    // disabled unit drops request
    // New field value, so the drop lands with the write itself
    if (next_st.psel == PPI_PSEL_OFF) begin
      next_st.req = 1'b0;
    end

    if (rd) begin
      if (addr == PPI_ADDR_CLK_CTRL) begin
        next_st.rdata[PPI_CLKS_LSB +: 2] = st.clk_sel;
        next_st.rdata[PPI_DRV_LSB +: 4] = st.drive;
        next_st.rdata[PPI_PEND_BIT] = st.pending;
      end else if (addr == PPI_ADDR_KB_EN) begin
        next_st.rdata[PPI_KBIE_LSB +: 4] = st.kb_en;
        next_st.rdata[PPI_PSEL_LSB +: 3] = st.psel;
      end else if (addr == PPI_ADDR_KB_STAT) begin
        next_st.rdata[PPI_KEYBOARD_SENSITIVITY_BIT] = st.sens;
        next_st.rdata[PPI_IMASK_BIT] = st.imask;
        next_st.rdata[PPI_KEYBOARD_FLAG_BIT] = keyboard_flag;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign rdata = st.rdata;
  assign periodic_request = st.req;
  assign keyboard_acknowledge = st.ack;
  assign keyboard_sensitivity = st.sens;
  assign keyboard_int_mask = st.imask;
  assign keyboard_pin_enable = st.kb_en;
  assign port_drive_enable_bits = st.drive;

endmodule

// ---- test/ppi_kb_model.sv ----
// Purpose: keyboard unit stand-in
// Assumes: one clock
// Notes: flag is sticky until ack
`timescale 1ns/100ps
module ppi_kb_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic ack,
  output logic flag
);
  always_ff @(posedge clk) begin
    flag <= rst_n && !ack && (flag || req);
  end
endmodule

// ---- test/ppi_unit_chk.sv ----
// Purpose: port checks for the periodic unit
// Assumes: one clock, sync reset
// Notes: bench keeps sources still around acks
`timescale 1ns/100ps
module ppi_unit_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic keyboard_flag,
  input wire logic periodic_request,
  input wire logic keyboard_acknowledge,
  input wire logic keyboard_sensitivity
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_ack_cause: assert property (keyboard_acknowledge |->
    $past(wr && addr == 2'h2 && wdata[2])) else $error("ack");
  chk_ack_clears: assert property (keyboard_acknowledge |->
    !periodic_request) else $error("ack clr");
  chk_rd_idle: assert property (!$past(rd) |->
    rdata == 8'h00) else $error("rd idle");
  chk_ack_zero: assert property ($past(rd && addr == 2'h2) |->
    !rdata[2]) else $error("ack rd");
  chk_sens_rw: assert property (wr && addr == 2'h2 |=>
    keyboard_sensitivity == $past(wdata[0])) else $error("sens");
  chk_off_drop: assert property (wr && addr == 2'h1 &&
    wdata[6:4] == 3'h0 |=> !periodic_request) else $error("off");
  chk_req_hold: assert property ($fell(periodic_request) |->
    keyboard_acknowledge || $past(wr && addr == 2'h1)) else $error("hold");
  chk_flag_read: assert property ($past(rd && addr == 2'h2) |->
    rdata[3] == $past(keyboard_flag)) else $error("flag");
  cover property ($rose(periodic_request));
  cover property (keyboard_acknowledge);
  cover property ($past(rd) && rdata[7]);
endmodule

// ---- test/ppi_unit_bench.sv ----
// Purpose: register-level test of the periodic unit
// Assumes: sources driven as slow synchronous levels
// Notes: long periods skipped to keep the run short
`timescale 1ns/100ps
module ppi_unit_bench;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, kbf, req, ack, sens, imask;
  logic [3:0] kbe, drv;
  logic [1:0] addr = 2'h0;
  logic [2:0] src = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, got;
  int error_cnt = 0, n_checks = 0;
  always #50 clk = ~clk;
  ppi_unit dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rc_clock(src[0]), .ext_clock(src[1]),
    .xtal_clock(src[2]), .keyboard_flag(kbf), .periodic_request(req),
    .keyboard_acknowledge(ack), .keyboard_sensitivity(sens),
    .keyboard_int_mask(imask), .keyboard_pin_enable(kbe),
    .port_drive_enable_bits(drv));
  ppi_kb_model kb (.clk(clk), .rst_n(rst_n), .req(req), .ack(ack),
    .flag(kbf));
  task chk8(input logic [7:0] e, input logic [7:0] a);
    n_checks++;
    if (a !== e) begin
      error_cnt++;
      $display("FAIL %0t got %h want %h", $time, a, e);
    end
  endtask
  // Off the edge, so a request launched by this edge has settled
  task chk_req(input logic e);
    #1;
    chk8({7'h00, e}, {7'h00, req});
  endtask
  task wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  // Two cycles per level keeps sources below half the clock rate
  task pulse(input logic [2:0] m, input int n);
    repeat (n) begin
      repeat (2) @(posedge clk);
      src <= m;
      repeat (2) @(posedge clk);
      src <= 3'h0;
    end
    repeat (3) @(posedge clk);
  endtask
  task run(input logic [1:0] cs, input logic [2:0] ps, input logic [2:0] m);
    int n;
    n = (cs == 2'h3) ? 600 : (1 << (8 + ps));
    wr_reg(2'h0, {6'h00, cs});
    wr_reg(2'h1, {1'b0, ps, 4'hF});
    wr_reg(2'h2, 8'h07);
    pulse(m, n - 1);
    chk_req(1'b0);
    pulse(m, 1);
    chk_req(cs != 2'h3);
    rd_reg(2'h0);
    chk8({cs != 2'h3, 5'h00, cs}, got);
    wr_reg(2'h2, 8'h07);
    rd_reg(2'h2);
    chk8(8'h03, got);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd_reg(a[1:0]);
      chk8(8'h00, got);
    end
    for (int c = 0; c < 3; c++) run(c[1:0], 3'h1, 3'(1 << c));
    for (int p = 2; p < 5; p++) run(2'h2, p[2:0], 3'h4);
    run(2'h3, 3'h1, 3'h7);
    run(2'h2, 3'h1, 3'h4);
    wr_reg(2'h1, 8'h10);
    pulse(3'h4, 512);
    wr_reg(2'h1, 8'h0F);
    chk_req(1'b0);
    rd_reg(2'h0);
    chk8(8'h82, got);
    chk8(8'h0F, {4'h0, kbe});
    chk8(8'h01, {7'h00, imask});
    chk8(8'h01, {7'h00, sens});
    wr_reg(2'h0, 8'h3E);
    rd_reg(2'h0);
    chk8(8'hBE, got);
    chk8(8'h0F, {4'h0, drv});
    give_verdict();
  end
endmodule
bind ppi_unit ppi_unit_chk u_chk (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .keyboard_flag(keyboard_flag), .periodic_request(periodic_request),
  .keyboard_acknowledge(keyboard_acknowledge),
  .keyboard_sensitivity(keyboard_sensitivity));
